/* File: design/vref_pkg.sv */
// Register map, field layout and timing constants of the reference control block
package vref_pkg;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  localparam logic [3:0] SYS_ADDR = 4'h8;
  localparam int EN_BIT = 7;
  localparam int RDY_BIT = 6;
  localparam int TEMP_SENSOR_ENABLE_BIT = 5;
  localparam int TEMP_RANGE_SELECT_BIT = 4;
  localparam int GAIN_LSB = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hB3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_1X = 2'h1;
  localparam logic [1:0] GAIN_2X = 2'h2;
  localparam logic [1:0] GAIN_4X = 2'h3;
  localparam logic [2:0] OSC_CFG_INTERNAL_OSCILLATOR = 3'h4;
  localparam logic [2:0] FREQ_SEL_HI3 = 3'h0;
  localparam logic [1:0] BOR_ALWAYS = 2'h3;
  localparam logic [1:0] BOR_NO_SLEEP = 2'h2;
  localparam logic [1:0] BOR_SOFT = 2'h1;
  localparam int SETTLE_NS = 25000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : vref_pkg

/* File: design/settle_timer.sv */
// Stabilisation timer that raises ready after the enable has stood long enough
module settle_timer
  import vref_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic enable,
  output logic settled
);
  logic [SETTLE_W-1:0] count;
  logic [SETTLE_W-1:0] next_count;
  logic next_settled;

  always_comb begin
    next_count = count;
    next_settled = settled;
    if (!enable) begin
      next_count = '0;
      next_settled = 1'b0;
    end else if (count == SETTLE_W'(SETTLE_CYCLES - 1)) begin
      next_settled = 1'b1;
    end else begin
      next_count = count + SETTLE_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      settled <= 1'b0;
    end else if (ce) begin
      count <= next_count;
      settled <= next_settled;
    end
  end
endmodule : settle_timer

/* File: design/vref_temp_ctrl.sv */
// Control/status register for the fixed reference and temperature indicator
//
// The address map and register access over AXI4-Lite were decided locally.
module vref_temp_ctrl
  import vref_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic std_voltage_variant,
  input wire logic [2:0] osc_config,
  input wire logic [3:0] internal_osc_freq_select,
  input wire logic [1:0] brownout_enable_config,
  input wire logic brownout_fast_start,
  input wire logic regulator_power_mode,
  input wire logic sleeping,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic reference_enable,
  output logic reference_ready_flag,
  output logic temp_sensor_enable,
  output logic temp_range_select,
  output logic [2:0] adc_ref_gain,
  output logic reference_required
);

  // Gain code to multiplier (0 means buffer off)
  function automatic logic [2:0] gain_of(input logic [1:0] code);
    case (code)
      GAIN_4X: gain_of = 3'h4;
      GAIN_2X: gain_of = 3'h2;
      GAIN_1X: gain_of = 3'h1;
      default: gain_of = 3'h0;
    endcase
  endfunction : gain_of

  // Pin-side inputs: three-stage synchronisers
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1;
  logic [NSYNC-1:0] s2;
  logic [NSYNC-1:0] s3;
  logic [NSYNC-1:0] pin_q;
  logic [NSYNC-1:0] next_pin_q;

  assign pin_raw = {std_voltage_variant, osc_config, internal_osc_freq_select,
                    brownout_enable_config, brownout_fast_start, regulator_power_mode, sleeping};

  always_comb begin
    next_pin_q = pin_q;
    for (int i = 0; i < NSYNC; i++) begin
      if (s2[i] == s3[i]) begin
        next_pin_q[i] = s3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pin_q <= '0;
    end else if (ce) begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      pin_q <= next_pin_q;
    end
  end

  logic std_q;
  logic [2:0] osc_q;
  logic [3:0] freq_q;
  logic [1:0] bor_q;
  logic bfs_q;
  logic vpm_q;
  logic sleep_q;
  assign {std_q, osc_q, freq_q, bor_q, bfs_q, vpm_q, sleep_q} = pin_q;

  // Requirement terms from other on-chip functions
  logic req_osc;
  logic req_bor;
  logic req_reg;
  assign req_osc = (osc_q == OSC_CFG_INTERNAL_OSCILLATOR) && (freq_q[3:1] == FREQ_SEL_HI3) && !sleep_q;
  assign req_bor = (bor_q == BOR_ALWAYS) ||
                   (((bor_q == BOR_NO_SLEEP) || (bor_q == BOR_SOFT)) && bfs_q);
  assign req_reg = std_q && vpm_q && !sleep_q;

  // Control register
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic settled;
  logic ready_now;
  logic req_any;

  settle_timer u_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .enable(ctrl[EN_BIT] | req_any),
    .settled(settled)
  );

  assign req_any = req_osc | req_bor | req_reg;
  assign ready_now = std_q | settled;

  // AXI4-Lite write path: address and data may arrive in either order
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [3:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic do_write;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_ctrl = ctrl;
    do_write = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      do_write = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (aw_addr[3:2] == CTRL_ADDR[3:2]) begin
        if (w_strb[0]) begin
          // Ready and unused bits keep their value
          next_ctrl = (ctrl & ~CTRL_WMASK) | (w_data[7:0] & CTRL_WMASK);
        end
      end else if (aw_addr[3:2] != STAT_ADDR[3:2] && aw_addr[3:2] != SYS_ADDR[3:2]) begin
        next_bresp = RESP_SLVERR;
      end
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      ctrl <= next_ctrl;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // Read path: one read at a time, answer registered on the accepting edge
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [7:0] ctrl_view;

  always_comb begin
    ctrl_view = ctrl;
    ctrl_view[RDY_BIT] = ready_now;
    ctrl_view[3:2] = 2'h0;
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (s_axi_araddr[3:2])
        CTRL_ADDR[3:2]: next_rdata = {24'h0, ctrl_view};
        STAT_ADDR[3:2]: next_rdata = {29'h0, req_any, settled, ready_now};
        SYS_ADDR[3:2]: next_rdata = {29'h0, req_reg, req_bor, req_osc};
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (!s_axi_rvalid && !next_rvalid) begin
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // Analog-side controls, registered so outputs come from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reference_enable <= 1'b0;
      reference_ready_flag <= 1'b0;
      temp_sensor_enable <= 1'b0;
      temp_range_select <= 1'b0;
      adc_ref_gain <= 3'h0;
      reference_required <= 1'b0;
    end else if (ce) begin
      // Other functions may force the reference on regardless of software
      reference_enable <= ctrl[EN_BIT] | req_any;
      reference_ready_flag <= ready_now;
      temp_sensor_enable <= ctrl[TEMP_SENSOR_ENABLE_BIT];
      temp_range_select <= ctrl[TEMP_RANGE_SELECT_BIT];
      adc_ref_gain <= gain_of(ctrl[GAIN_LSB+1:GAIN_LSB]);
      reference_required <= req_any;
    end
  end
endmodule : vref_temp_ctrl

/* File: test/vref_temp_ctrl_checker.sv */
// Port-level assertions for the reference control block
module vref_temp_ctrl_checker
  import vref_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic std_voltage_variant,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic reference_enable,
  input wire logic reference_ready_flag,
  input wire logic temp_sensor_enable,
  input wire logic temp_range_select,
  input wire logic [2:0] adc_ref_gain
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic wr_hs;
  logic ctl_wr;
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign ctl_wr = wr_hs && s_axi_awaddr == CTRL_ADDR && s_axi_wstrb[0];
  AST_WR_RESP: assert property (wr_hs |-> ##2 s_axi_bvalid) else $error("write response late");
  // Control register commits one edge after acceptance, the output flops one edge later
  AST_EN_SET: assert property (ctl_wr && s_axi_wdata[EN_BIT] |-> ##3 reference_enable) else $error("enable");
  AST_TS_EN: assert property (ctl_wr |-> ##3 temp_sensor_enable == $past(s_axi_wdata[TEMP_SENSOR_ENABLE_BIT], 3))
    else $error("temp enable");
  AST_RANGE: assert property (ctl_wr |-> ##3 temp_range_select == $past(s_axi_wdata[TEMP_RANGE_SELECT_BIT], 3))
    else $error("range");
  AST_GAIN: assert property (ctl_wr |-> ##3 {1'h0, adc_ref_gain} == (4'h1 << $past(s_axi_wdata[1:0], 3)) >> 1)
    else $error("gain decode");
  AST_GAIN_CODE: assert property ($onehot0(adc_ref_gain)) else $error("gain code");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  AST_RD_ZERO: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == CTRL_ADDR
    |=> s_axi_rdata[3:2] == 2'h0 && s_axi_rdata[31:8] == 24'h0) else $error("unused bits");
  AST_SETTLE: assert property ($rose(reference_ready_flag) && !std_voltage_variant
    |-> $past(reference_enable, 8)) else $error("ready early");
  AST_RST: assert property (disable iff (1'h0) !aresetn |=> !reference_enable && !temp_sensor_enable
    && !temp_range_select && adc_ref_gain == 3'h0 && !reference_ready_flag) else $error("reset");
  cover property (ctl_wr);
  cover property ($rose(reference_ready_flag));
  cover property (s_axi_arvalid && s_axi_arready);
endmodule : vref_temp_ctrl_checker

bind vref_temp_ctrl vref_temp_ctrl_checker vref_temp_ctrl_checker_i (.*);

/* File: test/tb.sv */
// Register-level bench for the reference control block
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb
  import vref_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, std_voltage_variant = 1'h0, brownout_fast_start = 1'h0;
  logic regulator_power_mode = 1'h0, sleeping = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [2:0] osc_config = 3'h0;
  logic [3:0] internal_osc_freq_select = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [1:0] brownout_enable_config = 2'h0, s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reference_required;
  logic reference_enable, reference_ready_flag, temp_sensor_enable, temp_range_select;
  logic [2:0] adc_ref_gain;
  logic [2:0] gains [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  // Pins: variant, osc cfg, freq, brown-out cfg, fast start, power mode, sleep, expected
  logic [13:0] tv [10] = '{14'h1041, 14'h1042, 14'h1080, 14'h0031, 14'h0029, 14'h0019, 14'h0010,
    14'h2005, 14'h2006, 14'h0004};
  int n_fail = 0, checks_done = 0, t, w;
  vref_temp_ctrl vref_temp_ctrl_i (.*);
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic hang(input int n);
    if (n >= 2000) begin
      n_fail++;
      test_done();
    end
  endtask : hang
  // Address and data offered together; each dropped once its ready is seen
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && t < 2000);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    hang(t);
    repeat (2) @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && t < 2000);
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    hang(t);
  endtask : rd
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(CTRL_ADDR);
    `CHK("ctrl reset", 32'h0, rd_data)
    wr(CTRL_ADDR, 8'hFF);
    `CHK("wr resp", RESP_OKAY, resp)
    rd(CTRL_ADDR);
    `CHK("ctrl ro bits", 32'hB3, rd_data)
    `CHK("enable", 1'h1, reference_enable)
    `CHK("temp enable", 1'h1, temp_sensor_enable)
    `CHK("range", 1'h1, temp_range_select)
    `CHK("ready early", 1'h0, reference_ready_flag)
    for (int g = 0; g < 4; g++) begin
      wr(CTRL_ADDR, 8'(g));
      `CHK("gain", gains[g], adc_ref_gain)
      `CHK("ready off", 1'h0, reference_ready_flag)
    end
    wr(CTRL_ADDR, 8'h80);
    for (w = 0; w < 2000 && reference_ready_flag !== 1'h1; w++) @(posedge aclk);
    hang(w);
    `CHK("settle", 1'h1, w > SETTLE_CYCLES - 10 && w < SETTLE_CYCLES + 10)
    rd(CTRL_ADDR);
    `CHK("ready bit", 32'hC0, rd_data)
    wr(CTRL_ADDR, 8'h00);
    repeat (4) @(posedge aclk);
    `CHK("ready cleared", 1'h0, reference_ready_flag)
    rd(4'hC);
    `CHK("unmapped", RESP_SLVERR, resp)
    // Pins pass a synchroniser, so each setting is given time to land
    for (int k = 0; k < 10; k++) begin
      {std_voltage_variant, osc_config, internal_osc_freq_select, brownout_enable_config, brownout_fast_start,
        regulator_power_mode, sleeping} <= tv[k][13:1];
      repeat (12) @(posedge aclk);
      `CHK("required", tv[k][0], reference_required)
    end
    // Last vector leaves the low-voltage variant selected
    regulator_power_mode <= 1'h0;
    std_voltage_variant <= 1'h1;
    repeat (12) @(posedge aclk);
    `CHK("std ready", 1'h1, reference_ready_flag)
    rd(CTRL_ADDR);
    `CHK("std ctrl", 32'h40, rd_data)
    wr(CTRL_ADDR, 8'hFF);
    std_voltage_variant <= 1'h0;
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(CTRL_ADDR);
    `CHK("ctrl rereset", 32'h0, rd_data)
    `CHK("gain rereset", 3'h0, adc_ref_gain)
    test_done();
  end
endmodule : tb
